// ---- hdl/isq_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
// Bit-level sequencer: drives the open-drain lines through enables (low when enabled).
module isq_engine (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic goStart,
  input wire logic goRestart,
  input wire logic goStop,
  input wire logic goRecv,
  input wire logic goAck,
  input wire logic goTx,
  input wire logic ackValue,
  input wire logic [7:0] txByte,
  input wire logic sdaSync,
  input wire logic sclSync,
  output logic busy,
  output logic done,
  output logic ackValid,
  output logic ackSeen,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic sdaLow,
  output logic sclLow
);
  import isq_pkg::*;

  isq_state_e state_q, state_d;
  logic [1:0] phase_q, phase_d;
  logic [15:0] tick_q, tick_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] sh_q, sh_d;
  logic sda_q, sda_d, scl_q, scl_d;
  logic done_q, done_d, av_q, av_d, as_q, as_d, rv_q, rv_d;
  logic tickEnd, sclHeld;

  // A slave holding the clock low parks the count at zero; the high phase is timed from the real rise.
  assign sclHeld = !scl_q && !sclSync;
  assign tickEnd = (tick_q == 16'(HALF_CYCLES - 1)) && !sclHeld;

  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    tick_d = (tickEnd || sclHeld) ? 16'h0000 : tick_q + 16'h0001;
    bits_d = bits_q;
    sh_d = sh_q;
    sda_d = sda_q;
    scl_d = scl_q;
    done_d = 1'b0;
    av_d = 1'b0;
    as_d = as_q;
    rv_d = 1'b0;
    case (state_q)
      ISQ_IDLE: begin
        tick_d = 16'h0000;
        phase_d = 2'd0;
        bits_d = 4'h0;
        if (goStart) begin
          state_d = ISQ_START;
        end else if (goRestart) begin
          state_d = ISQ_RESTART;
          scl_d = 1'b1;
        end else if (goStop) begin
          state_d = ISQ_STOP;
          sda_d = 1'b1;
        end else if (goRecv) begin
          state_d = ISQ_RX;
          sda_d = 1'b0;
        end else if (goAck) begin
          state_d = ISQ_ACK;
          sda_d = !ackValue;
        end else if (goTx) begin
          state_d = ISQ_TX;
          sh_d = txByte;
          sda_d = !txByte[7];
        end
      end
      ISQ_START, ISQ_RESTART: begin
        if (tickEnd) begin
          phase_d = phase_q + 2'd1;
          if (state_q == ISQ_RESTART && phase_q == 2'd0) begin
            sda_d = 1'b0;
          end else if (state_q == ISQ_RESTART && phase_q == 2'd1) begin
            scl_d = 1'b0;
          end else if (state_q == ISQ_RESTART && phase_q == 2'd2) begin
            sda_d = 1'b1;
          end else if (state_q == ISQ_START && phase_q == 2'd0) begin
            sda_d = 1'b1;
          end else begin
            scl_d = 1'b1;
            state_d = ISQ_IDLE;
            done_d = 1'b1;
          end
        end
      end
      ISQ_STOP: begin
        if (tickEnd) begin
          phase_d = phase_q + 2'd1;
          if (phase_q == 2'd0) begin
            scl_d = 1'b0;
          end else begin
            sda_d = 1'b0;
            state_d = ISQ_IDLE;
            done_d = 1'b1;
          end
        end
      end
      ISQ_TX, ISQ_RX, ISQ_ACK, ISQ_TXACK: begin
        if (tickEnd) begin
          scl_d = !scl_q;
          if (scl_q) begin
            bits_d = bits_q + 4'h1;
            if (state_q == ISQ_RX) begin
              sh_d = {sh_q[6:0], sdaSync};
            end else if (state_q == ISQ_TXACK) begin
              as_d = sdaSync;
            end
          end else if (bits_q != 4'h0) begin
            if (state_q == ISQ_TX && bits_q == 4'(BIT_COUNT)) begin
              state_d = ISQ_TXACK;
              bits_d = 4'h0;
              sda_d = 1'b0;
            end else if (state_q == ISQ_TX) begin
              sh_d = {sh_q[6:0], 1'b0};
              sda_d = !sh_q[6];
            end else if (state_q != ISQ_RX || bits_q == 4'(BIT_COUNT)) begin
              state_d = ISQ_IDLE;
              sda_d = 1'b0;
              done_d = 1'b1;
              rv_d = (state_q == ISQ_RX);
              av_d = (state_q == ISQ_TXACK);
            end
          end
        end
      end
      default: begin
        state_d = ISQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= ISQ_IDLE;
      phase_q <= 2'd0;
      tick_q <= 16'h0000;
      bits_q <= 4'h0;
      sh_q <= 8'h00;
      sda_q <= 1'b0;
      scl_q <= 1'b0;
      done_q <= 1'b0;
      av_q <= 1'b0;
      as_q <= 1'b1;
      rv_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      tick_q <= tick_d;
      bits_q <= bits_d;
      sh_q <= sh_d;
      sda_q <= sda_d;
      scl_q <= scl_d;
      done_q <= done_d;
      av_q <= av_d;
      as_q <= as_d;
      rv_q <= rv_d;
    end
  end

  assign busy = (state_q != ISQ_IDLE);
  assign done = done_q;
  assign ackValid = av_q;
  assign ackSeen = as_q;
  assign rxValid = rv_q;
  assign rxByte = sh_q;
  assign sdaLow = sda_q;
  assign sclLow = scl_q;
endmodule : isq_engine
`default_nettype wire

// ---- hdl/isq_pkg.sv ----
package isq_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_SEQ_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA_BUF = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
  // Sequence control field positions.
  localparam int BIT_START = 0;
  localparam int BIT_RESTART = 1;
  localparam int BIT_STOP = 2;
  localparam int BIT_RECV = 3;
  localparam int BIT_ACKSEQ = 4;
  localparam int BIT_ACKVAL = 5;
  localparam int BIT_SLAVE_ACK_STATUS = 6;
  // Mode register: bit 0 selects master operation.
  localparam int BIT_MASTER = 0;
  // Interrupt status bits.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NACK = 1;
  localparam int IRQ_WIDTH = 2;
  // Reset values.
  localparam logic [7:0] SEQ_CTRL_RESET = 8'h00;
  localparam logic MODE_RESET = 1'b1;
  // Bus timing: half bit period of the generated bus clock.
  localparam int HALF_PERIOD_NS = 2500;
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_CYCLES = HALF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BIT_COUNT = 8;
  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ISQ_IDLE = 4'h0,
    ISQ_START = 4'h1,
    ISQ_RESTART = 4'h3,
    ISQ_STOP = 4'h2,
    ISQ_TX = 4'h6,
    ISQ_RX = 4'h7,
    ISQ_ACK = 4'h5,
    ISQ_TXACK = 4'h4
  } isq_state_e;
endpackage : isq_pkg

// ---- hdl/isq_sequence_control.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - As transmitting master, capture the slave's acknowledge of the last byte as status.
// - In master receive, send the software-selected acknowledge value; 1 is not-acknowledge.
// - Acknowledge request runs an acknowledge sequence, then clears itself.
// - Receive request starts one-byte reception; cleared bit means receiver idle (the bit clears as the engine takes the request, while reception still runs).
// - Stop request generates a stop condition, then clears itself.
// - Restart request generates a repeated start, then clears itself.
// - Start request generates a start condition, then clears itself.
// - While busy, no sequence request bit may be set (in slave mode the start bit is still written while busy).
// - While busy, writes to the data buffer are ignored.
module isq_sequence_control (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  output logic clock_stretch_enable,
  output logic irq
);
  import isq_pkg::*;

  logic [1:0] sdaSync_q, sclSync_q;
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] dataBuf_q, dataBuf_d;
  logic master_q, master_d;
  logic txPend_q, txPend_d;
  logic [IRQ_WIDTH-1:0] irqStat_q, irqStat_d, irqEn_q, irqEn_d;
  logic sdaOe_q, sclOe_q, irq_q, stretch_q, awReady_q, wReady_q, arReady_q;
  logic busy, done, ackValid, ackSeen, rxValid, sdaLow, sclLow;
  logic [7:0] rxByte;
  logic doWrite, goStart, goRestart, goStop, goRecv, goAck, goTx;
  logic [IRQ_WIDTH-1:0] irqEvent, irqClr;

  // Both lines pass a two-stage synchroniser; only the second stage is read.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sdaSync_q <= 2'b11;
      sclSync_q <= 2'b11;
    end else begin
      sdaSync_q <= {sdaSync_q[0], sda_in};
      sclSync_q <= {sclSync_q[0], scl_in};
    end
  end

  // Launch a sequence one cycle after its request bit is set, only in master mode.
  assign goStart = master_q && ctrl_q[BIT_START];
  assign goRestart = master_q && ctrl_q[BIT_RESTART];
  assign goStop = master_q && ctrl_q[BIT_STOP];
  assign goRecv = master_q && ctrl_q[BIT_RECV];
  assign goAck = master_q && ctrl_q[BIT_ACKSEQ];
  assign goTx = master_q && txPend_q;

  isq_engine u_engine (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .goStart(goStart),
    .goRestart(goRestart),
    .goStop(goStop),
    .goRecv(goRecv),
    .goAck(goAck),
    .goTx(goTx),
    .ackValue(ctrl_q[BIT_ACKVAL]),
    .txByte(dataBuf_q),
    .sdaSync(sdaSync_q[1]),
    .sclSync(sclSync_q[1]),
    .busy(busy),
    .done(done),
    .ackValid(ackValid),
    .ackSeen(ackSeen),
    .rxValid(rxValid),
    .rxByte(rxByte),
    .sdaLow(sdaLow),
    .sclLow(sclLow)
  );

  assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
  assign irqEvent = {ackValid && ackSeen, done};
  assign irqClr = (doWrite && awAddr_q == ADDR_IRQ_CLEAR && wStrb_q[0]) ? wData_q[IRQ_WIDTH-1:0] : '0;

  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ctrl_d = ctrl_q;
    dataBuf_d = dataBuf_q;
    master_d = master_q;
    txPend_d = txPend_q && !goTx;
    irqEn_d = irqEn_q;
    // Set wins over clear for sticky status.
    irqStat_d = (irqStat_q & ~irqClr) | irqEvent;
    if (s_axi_awvalid && !awHeld_q) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_q) begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    // Request bits self-clear once the engine has taken them.
    if (goStart) ctrl_d[BIT_START] = 1'b0;
    if (goRestart) ctrl_d[BIT_RESTART] = 1'b0;
    if (goStop) ctrl_d[BIT_STOP] = 1'b0;
    if (goAck) ctrl_d[BIT_ACKSEQ] = 1'b0;
    if (goRecv) ctrl_d[BIT_RECV] = 1'b0;
    if (ackValid) ctrl_d[BIT_SLAVE_ACK_STATUS] = ackSeen;
    if (rxValid) dataBuf_d = rxByte;
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (awAddr_q)
        ADDR_SEQ_CTRL: begin
          if (wStrb_q[0]) begin
            ctrl_d[BIT_ACKVAL] = wData_q[BIT_ACKVAL];
            ctrl_d[7] = wData_q[7];
            // Requests are refused while a sequence runs or one is pending, except the start bit in slave mode; no queueing.
            if (!busy && !goStart && !goRestart && !goStop && !goRecv && !goAck && !txPend_q) begin
              ctrl_d[4:0] = wData_q[4:0];
            end else if (!master_q) begin
              ctrl_d[BIT_START] = wData_q[BIT_START];
            end
          end
        end
        ADDR_DATA_BUF: begin
          if (wStrb_q[0] && !busy && !txPend_q) begin
            dataBuf_d = wData_q[7:0];
            txPend_d = master_q;
          end
        end
        ADDR_MODE: begin
          if (wStrb_q[0]) master_d = wData_q[BIT_MASTER];
        end
        ADDR_IRQ_ENABLE: begin
          if (wStrb_q[0]) irqEn_d = wData_q[IRQ_WIDTH-1:0];
        end
        ADDR_IRQ_CLEAR: begin
        end
        default: begin
          bresp_d = RESP_SLVERR;
        end
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (s_axi_araddr)
        ADDR_SEQ_CTRL: rdata_d[7:0] = ctrl_q;
        ADDR_DATA_BUF: rdata_d[7:0] = dataBuf_q;
        ADDR_MODE: rdata_d[0] = master_q;
        ADDR_IRQ_STATUS: rdata_d[IRQ_WIDTH-1:0] = irqStat_q;
        ADDR_IRQ_ENABLE: rdata_d[IRQ_WIDTH-1:0] = irqEn_q;
        ADDR_IRQ_CLEAR: rdata_d = 32'h0000_0000;
        default: rresp_d = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      ctrl_q <= SEQ_CTRL_RESET;
      dataBuf_q <= 8'h00;
      master_q <= MODE_RESET;
      txPend_q <= 1'b0;
      irqStat_q <= '0;
      irqEn_q <= '0;
      sdaOe_q <= 1'b0;
      sclOe_q <= 1'b0;
      irq_q <= 1'b0;
      stretch_q <= 1'b0;
      awReady_q <= 1'b1;
      wReady_q <= 1'b1;
      arReady_q <= 1'b1;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      dataBuf_q <= dataBuf_d;
      master_q <= master_d;
      txPend_q <= txPend_d;
      irqStat_q <= irqStat_d;
      irqEn_q <= irqEn_d;
      sdaOe_q <= sdaLow;
      sclOe_q <= sclLow;
      irq_q <= |(irqStat_d & irqEn_d);
      stretch_q <= !master_d && ctrl_d[BIT_START];
      awReady_q <= !awHeld_d;
      wReady_q <= !wHeld_d;
      arReady_q <= !rvalid_d;
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  // Open-drain: the pins only ever pull low.
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe = sdaOe_q;
  assign scl_oe = sclOe_q;
  assign clock_stretch_enable = stretch_q;
  assign irq = irq_q;
endmodule : isq_sequence_control
`default_nettype wire

// ---- sim/isq_sequence_control_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module isq_sequence_control_assertions (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sda_oe,
  input wire logic scl_oe
);
  import isq_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after)
    else $error("read answer late");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after)
    else $error("write answer late");
  property p_slverr;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("refused read returned data");
  // A start holds the data line low under a high clock before the first bit.
  property p_start;
    $rose(sda_oe) && !scl_oe |=> (sda_oe && !scl_oe) [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("start condition too short");
  property p_stop;
    $fell(sda_oe) && !scl_oe |=> (!sda_oe && !scl_oe) [*8];
  endproperty
  a_stop: assert property (p_stop)
    else $error("bus not left free after stop");
  property p_scl_low;
    $rose(scl_oe) |=> scl_oe [*8];
  endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("clock low phase too short");
endmodule : isq_sequence_control_assertions
bind isq_sequence_control isq_sequence_control_assertions u_chk (.*);
`default_nettype wire

// ---- sim/isq_sequence_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module isq_sequence_control_tb;
  import isq_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} isq_row_s;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, g;
  logic sda_in, scl_in, sda_out, sda_oe, scl_out, scl_oe, clock_stretch_enable, irq;
  logic sdaLow, sclLow, masterAck, ackOff = 1'b0, readMode = 1'b0, stretch = 1'b0;
  logic [7:0] rxData;
  int bad_count = 0, n_compared = 0;
  isq_row_s rows [12];
  // Both lines are pulled up; any party pulling makes them low.
  assign sda_in = !(sda_oe || sdaLow);
  assign scl_in = !(scl_oe || sclLow);
  always #5 ref_clk = ~ref_clk;
  isq_sequence_control uut (.*);
  isq_slave_model slave (.sclLine(scl_in), .sdaLine(sda_in), .ackOff(ackOff), .readMode(readMode),
    .stretch(stretch), .txData(8'h96), .sdaLow(sdaLow), .sclLow(sclLow), .rxData(rxData), .masterAck(masterAck));
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) begin
      bad_count++;
      end_sim();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    g = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      bad_count++;
      end_sim();
    end
  endtask : rd
  // Polls the done flag, checks the interrupt line, then clears the flag.
  task automatic wait_done(input logic e);
    int n;
    g = 32'h0;
    for (n = 0; n < 3000 && g[IRQ_DONE] !== 1'b1; n++) rd(ADDR_IRQ_STATUS);
    if (g[IRQ_DONE] !== 1'b1) begin
      bad_count++;
      end_sim();
    end
    chk(irq, e);
    wr(ADDR_IRQ_CLEAR, 32'h1);
  endtask : wait_done
  initial begin
    rows = '{'{1'b0, ADDR_SEQ_CTRL, 32'h0, 32'h0, RESP_OKAY}, '{1'b0, ADDR_MODE, 32'h0, 32'h1, RESP_OKAY},
      '{1'b0, ADDR_IRQ_STATUS, 32'h0, 32'h0, RESP_OKAY}, '{1'b0, ADDR_IRQ_ENABLE, 32'h0, 32'h0, RESP_OKAY},
      '{1'b1, ADDR_IRQ_ENABLE, 32'h3, 32'h0, RESP_OKAY}, '{1'b0, ADDR_IRQ_ENABLE, 32'h0, 32'h3, RESP_OKAY},
      '{1'b1, ADDR_SEQ_CTRL, 32'hc0, 32'h0, RESP_OKAY}, '{1'b0, ADDR_SEQ_CTRL, 32'h0, 32'h80, RESP_OKAY},
      '{1'b0, ADDR_IRQ_CLEAR, 32'h0, 32'h0, RESP_OKAY}, '{1'b0, 8'h18, 32'h0, 32'h0, RESP_SLVERR},
      '{1'b1, 8'h18, 32'h1, 32'h0, RESP_SLVERR}, '{1'b1, ADDR_SEQ_CTRL, 32'h0, 32'h0, RESP_OKAY}};
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a);
        chk(g, rows[i].e);
      end
      chk(r, rows[i].r);
    end
    wr(ADDR_SEQ_CTRL, 32'h1);
    wr(ADDR_SEQ_CTRL, 32'h4);
    rd(ADDR_SEQ_CTRL);
    chk(g & 32'h1f, 32'h0);
    wait_done(1'b1);
    chk(sda_oe, 1'b1);
    wr(ADDR_IRQ_ENABLE, 32'h2);
    ackOff <= 1'b1;
    stretch <= 1'b1;
    wr(ADDR_DATA_BUF, 32'h5a);
    wait_done(1'b1);
    chk(rxData, 8'h5a);
    rd(ADDR_SEQ_CTRL);
    chk(g[BIT_SLAVE_ACK_STATUS], 1'b1);
    ackOff <= 1'b0;
    stretch <= 1'b0;
    wr(ADDR_IRQ_CLEAR, 32'h2);
    wr(ADDR_DATA_BUF, 32'ha5);
    wr(ADDR_DATA_BUF, 32'h3c);
    wait_done(1'b0);
    chk(rxData, 8'ha5);
    rd(ADDR_DATA_BUF);
    chk(g, 32'ha5);
    rd(ADDR_SEQ_CTRL);
    chk(g[BIT_SLAVE_ACK_STATUS], 1'b0);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    rd(ADDR_IRQ_STATUS);
    chk(g, 32'h0);
    chk(irq, 1'b0);
    readMode <= 1'b1;
    wr(ADDR_SEQ_CTRL, 32'h2);
    wait_done(1'b1);
    for (int v = 0; v < 2; v++) begin
      wr(ADDR_SEQ_CTRL, 32'h8);
      wait_done(1'b1);
      rd(ADDR_DATA_BUF);
      chk(g, 32'h96);
      wr(ADDR_SEQ_CTRL, {26'h0, v[0], 5'h10});
      wait_done(1'b1);
      chk(masterAck, v[0]);
      rd(ADDR_SEQ_CTRL);
      chk(g & 32'h1f, 32'h0);
    end
    readMode <= 1'b0;
    wr(ADDR_SEQ_CTRL, 32'h4);
    wait_done(1'b1);
    chk({sda_oe, scl_oe, sda_out, scl_out}, 4'h0);
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_SEQ_CTRL, 32'h1);
    rd(ADDR_SEQ_CTRL);
    chk({clock_stretch_enable, sda_oe}, 2'b10);
    wr(ADDR_SEQ_CTRL, 32'h0);
    rd(ADDR_SEQ_CTRL);
    chk(clock_stretch_enable, 1'b0);
    wr(ADDR_SEQ_CTRL, 32'h1);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({clock_stretch_enable, irq, s_axi_bvalid, s_axi_rvalid, sda_oe, scl_oe}, 6'h0);
    resetn <= 1'b1;
    rd(ADDR_MODE);
    chk(g, 32'h1);
    rd(ADDR_SEQ_CTRL);
    chk(g, 32'h0);
    end_sim();
  end
  initial begin
    #1000000;
    bad_count++;
    end_sim();
  end
endmodule : isq_sequence_control_tb
`default_nettype wire

// ---- sim/isq_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module isq_slave_model (
  input wire logic sclLine,
  input wire logic sdaLine,
  input wire logic ackOff,
  input wire logic readMode,
  input wire logic stretch,
  input wire logic [7:0] txData,
  output logic sdaLow,
  output logic sclLow,
  output logic [7:0] rxData,
  output logic masterAck
);
  int cnt = 0;
  logic nak = 1'b0;
  initial begin
    sdaLow = 1'b0;
    sclLow = 1'b0;
    rxData = 8'h00;
    masterAck = 1'b1;
  end
  always @(negedge sdaLine) if (sclLine) begin
    cnt = 0;
    nak = 1'b0;
  end
  always @(posedge sclLine) begin
    if (cnt < 8) rxData = {rxData[6:0], sdaLine};
    else begin
      masterAck = sdaLine;
      nak = sdaLine;
    end
    cnt = cnt + 1;
  end
  // Data only changes while the clock is low; after a not-acknowledge the line is let go.
  always @(negedge sclLine) begin
    if (cnt == 9) cnt = 0;
    if (!readMode) sdaLow = (cnt == 8) && !ackOff;
    else sdaLow = (cnt < 8) && !nak && !txData[7 - cnt];
    // Held past the master's own low phase, so the master has to wait for the line.
    if (stretch) begin
      sclLow = 1'b1;
      #4000 sclLow = 1'b0;
    end
  end
endmodule : isq_slave_model
`default_nettype wire
